// file: shared/tbc_defines.vh
// Constants for the trace buffer and final-state controller.
// Included by the design file; holds definitions only.
`ifndef TBC_DEFINES_VH
`define TBC_DEFINES_VH

// Register byte offsets (word aligned)
`define TBC_OFS_CTRL      5'h00
`define TBC_OFS_STATUS    5'h04
`define TBC_OFS_TRACE     5'h08
`define TBC_OFS_CMPC      5'h0c
`define TBC_OFS_CMPD      5'h10

// Control register fields
`define TBC_CTL_ARM       0
`define TBC_CTL_TRIG      1
`define TBC_CTL_BRKEN     2
`define TBC_CTL_ALIGN     5:4
`define TBC_CTL_TSE       6
`define TBC_CTL_MODE      9:8
`define TBC_CTL_TIMESTAMP_ENABLE     10
`define TBC_CTL_RANGE     13:12
`define TBC_CTL_EEV       15:14
`define TBC_CTL_MASK      32'h0000_f777
`define TBC_CTL_RESET     32'h0000_0000

// Sequencer states
`define TBC_ST_IDLE       2'h0
`define TBC_ST_ARMED      2'h1
`define TBC_ST_FINAL      2'h2

// Trigger alignment
`define TBC_AL_END        2'h0
`define TBC_AL_BEGIN      2'h1
`define TBC_AL_MID        2'h2

// Trace modes
`define TBC_MD_NORMAL     2'h0
`define TBC_MD_LOOP1      2'h1
`define TBC_MD_DETAIL     2'h2
`define TBC_MD_PUREPC     2'h3

// External event use
`define TBC_EEV_OFF       2'h0
`define TBC_EEV_FORCE     2'h1
`define TBC_EEV_GATE      2'h2

// Trace range select
`define TBC_RG_INSIDE     2'h1

// Flow instruction kinds reported by the core
`define TBC_K_CONDBR      4'h1
`define TBC_K_LOOP        4'h2
`define TBC_K_IJMP        4'h3
`define TBC_K_IJSR        4'h4
`define TBC_K_RTI         4'h5
`define TBC_K_RTS         4'h6
`define TBC_K_VECTOR      4'h7

// Entry type codes in the info byte
`define TBC_CET_NONCOF    2'h0
`define TBC_CET_SRC       2'h1
`define TBC_CET_DST       2'h2
`define TBC_CET_VEC       2'h3

// Info byte bit positions inside a 32-bit entry
`define TBC_INF_MARK      28
`define TBC_INF_EEVI      26

// Session lengths in lines
`define TBC_BEGIN_LINES   7'h40
`define TBC_MID_LINES     7'h20

`define TBC_INVALID_WORD  16'h0000

`endif

// file: tb/tb_top.sv
// Self-checking bench for the trace controller.
// Assumes one clock; core model feeds the flow strobes.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, rd = 0, wr = 0, trig = 0, bdc = 0, go = 0, mix = 0, eev = 0;
  logic [4:0]  adr = 0;
  logic [31:0] wd = 0, q, rdat;
  logic [3:0]  be = 0, kind;
  logic [7:0]  n = 1;
  logic [23:0] caddr;
  logic [1:0]  state_o;
  logic        wrq, brk, armed, busy, cval;
  int bad_count = 0, checks = 0, brk_n = 0;
  tbc_core_model core (.clk_i(clk_i), .go_i(go), .n_i(n), .mix_i(mix), .busy_o(busy),
    .cof_valid_o(cval), .cof_kind_o(kind), .cof_addr_o(caddr));
  tbc_trace_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
    .trigger_i(trig), .cof_valid_i(cval), .cof_kind_i(kind), .cof_addr_i(caddr), .pc_valid_i(cval),
    .pc_i(caddr), .acc_valid_i(cval), .acc_addr_i(caddr), .acc_data_i(16'h0), .acc_write_i(1'b0),
    .bdc_active_i(bdc), .eev_pin_i(eev), .brk_req_o(brk), .armed_o(armed), .state_o(state_o));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (brk === 1'b1) brk_n++;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    adr <= a; wd <= d; be <= 4'hf; wr <= w; rd <= !w;
    do begin @(posedge clk_i); k++; end while (wrq !== 1'b0 && k < 50);
    q = rdat;
    wr <= 1'b0; rd <= 1'b0;
    if (k >= 50) chk("bus answer", 1, 0);
  endtask
  task automatic run(input logic [7:0] c, input logic m);
    int k;
    k = 0;
    @(posedge clk_i);
    go <= 1'b1; n <= c; mix <= m;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    while (busy && k < 300) begin @(posedge clk_i); k++; end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic fire();
    @(posedge clk_i);
    trig <= 1'b1;
    @(posedge clk_i);
    trig <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic sc_reset();
    bus(0, 5'h00, 0); chk("ctrl reset", 0, q);
    bus(0, 5'h04, 0); chk("status reset", 0, q);
    bus(1, 5'h14, 32'h1234); bus(0, 5'h14, 0); chk("unmapped", 0, q);
  endtask
  task automatic sc_end();
    logic [7:0] ib;
    // Armed flag moves at the completing edge, so look once it has settled
    bus(1, 5'h00, 32'h45); @(negedge clk_i); chk("armed", 1, armed);
    run(9, 1);
    bus(0, 5'h08, 0); chk("read armed", 0, q[15:0]);
    brk_n = 0;
    fire(); chk("end brk", 1, brk_n);
    chk("end state", 0, state_o);
    bus(0, 5'h04, 0); chk("end count", 7, q[14:8]);
    for (int i = 1; i < 8; i++) begin
      ib = i < 3 ? 8'h40 : (i < 7 ? 8'h80 : 8'hc0);
      bus(0, 5'h08, 0); chk("entry lo", i, q[15:0]);
      bus(0, 5'h08, 0); chk("entry hi", {ib, 8'h0a}, q[15:0]);
    end
  endtask
  task automatic sc_quiet();
    bus(1, 5'h00, 32'h05); run(4, 0); brk_n = 0;
    fire(); chk("off brk", 1, brk_n);
    bus(0, 5'h04, 0); chk("off count", 0, q[14:8]);
    bus(1, 5'h00, 32'h45); bdc <= 1'b1; run(4, 0); bdc <= 1'b0;
    bus(1, 5'h00, 0); chk("disarm brk", 1, brk_n);
    bus(0, 5'h04, 0); chk("bdc count", 0, q[14:8]);
  endtask
  task automatic sc_mid();
    bus(1, 5'h00, 32'h65); run(10, 0); brk_n = 0;
    fire(); run(63, 0); chk("mid hold", 2, state_o);
    chk("mid early brk", 0, brk_n);
    run(1, 0); chk("mid done", 0, state_o);
    chk("mid brk", 1, brk_n);
    bus(0, 5'h04, 0); chk("mid count", 74, q[14:8]);
  endtask
  task automatic sc_begin();
    bus(1, 5'h00, 32'h51); run(4, 0);
    bus(0, 5'h04, 0); chk("begin pre", 0, q[14:8]);
    brk_n = 0;
    fire(); run(127, 0); chk("begin hold", 2, state_o);
    run(1, 0); chk("begin done", 0, state_o);
    chk("begin brk", 0, brk_n);
  endtask
  task automatic sc_events();
    bus(1, 5'h00, 32'h8045); run(4, 0);
    bus(0, 5'h04, 0); chk("gated count", 0, q[14:8]);
    eev <= 1'b1; repeat (3) @(posedge clk_i); run(4, 0);
    bus(0, 5'h04, 0); chk("gate open count", 4, q[14:8]);
    eev <= 1'b0; bus(1, 5'h00, 0); bus(1, 5'h00, 32'h4045);
    eev <= 1'b1; repeat (6) @(posedge clk_i); eev <= 1'b0;
    bus(0, 5'h04, 0); chk("forced count", 1, q[14:8]);
    bus(1, 5'h00, 0); bus(1, 5'h00, 32'h4345);
    eev <= 1'b1; repeat (6) @(posedge clk_i); eev <= 1'b0;
    bus(0, 5'h04, 0); chk("pure pc force", 0, q[14:8]);
    bus(1, 5'h00, 0); bus(1, 5'h0c, 32'h0a0001); bus(1, 5'h10, 32'h0a0002);
    bus(1, 5'h00, 32'h1245); run(4, 0); bus(1, 5'h00, 0);
    bus(0, 5'h04, 0); chk("window count", 2, q[14:8]);
    bus(0, 5'h08, 0); chk("window first", 1, q[15:0]);
  endtask
  task automatic sc_wrap();
    bus(1, 5'h00, 32'h45); run(130, 0);
    bus(0, 5'h04, 0); chk("wrapped", 1, q[3]);
    fire(); bus(0, 5'h08, 0); chk("oldest", 2, q[15:0]);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_reset();
    sc_end();
    sc_quiet();
    sc_mid();
    sc_begin();
    sc_wrap();
    sc_events();
    stop_test();
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire

// file: tb/tbc_core_model.sv
// Processor core model: issues one flow instruction a cycle on request.
// Assumes go_i is a one-cycle pulse while busy_o is low.
`timescale 1ns/1ps
`default_nettype none
module tbc_core_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [7:0]  n_i,
  input  wire logic        mix_i,
  output var  logic        busy_o,
  output var  logic        cof_valid_o,
  output var  logic [3:0]  cof_kind_o,
  output var  logic [23:0] cof_addr_o
);
  logic [7:0] idx_ff;
  initial begin
    busy_o = 1'b0;
    idx_ff = 8'h00;
    cof_valid_o = 1'b0;
    cof_kind_o = 4'h0;
    cof_addr_o = 24'h000000;
  end
  always @(posedge clk_i) begin
    cof_valid_o <= 1'b0;
    // Idle bus toggles so a stale value never looks valid
    cof_addr_o <= ~cof_addr_o;
    cof_kind_o <= ~cof_kind_o;
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      idx_ff <= 8'h00;
    end else if (busy_o) begin
      cof_valid_o <= 1'b1;
      // Mixed run walks kind codes 0 to 8, ignored ones included
      cof_kind_o <= mix_i ? 4'(idx_ff % 9) : 4'h1;
      cof_addr_o <= 24'h0a0000 + 24'(idx_ff);
      idx_ff <= idx_ff + 8'h01;
      if (idx_ff + 8'h01 == n_i) busy_o <= 1'b0;
    end
  end
endmodule // tbc_core_model
`default_nettype wire

// file: tb/tbc_trace_monitor.sv
// Port checker for the trace controller.
// Assumes full-word CTRL writes; bound to the design below.
`timescale 1ns/1ps
`default_nettype none
module tbc_trace_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        trigger_i,
  input wire logic        brk_req_o,
  input wire logic        armed_o,
  input wire logic [1:0]  state_o
);
  logic [31:0] ctl_ff;
  wire         wr_ctl = avs_write_i && !avs_waitrequest_o && avs_address_i[4:2] == 3'h0;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) ctl_ff <= 32'h0;
    else if (wr_ctl) ctl_ff <= avs_writedata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_armed_state: assert property (armed_o == (state_o != 2'h0))
    else $error("armed flag disagrees with state");
  chk_brk_at_idle: assert property (brk_req_o |-> state_o == 2'h0 && $past(armed_o) && ctl_ff[2])
    else $error("breakpoint request outside a return to idle");
  chk_brk_single: assert property (brk_req_o |=> !brk_req_o)
    else $error("breakpoint request longer than one cycle");
  chk_arm_enter: assert property (wr_ctl && avs_writedata_i[1:0] == 2'h1 && state_o == 2'h0 |=> state_o == 2'h1)
    else $error("arm write did not enter state 1");
  chk_disarm_quiet: assert property (wr_ctl && !avs_writedata_i[0] && state_o == 2'h1
    |=> state_o == 2'h0 && !brk_req_o ##1 !brk_req_o)
    else $error("disarm write misbehaved");
  chk_end_final: assert property (trigger_i && state_o == 2'h1 && (!ctl_ff[6] || ctl_ff[4] == ctl_ff[5])
    |=> state_o == 2'h2 ##1 state_o == 2'h0 && brk_req_o == ctl_ff[2])
    else $error("final state did not return at once");
  chk_hold_final: assert property (trigger_i && state_o == 2'h1 && ctl_ff[6] && ctl_ff[4] != ctl_ff[5]
    |=> (state_o == 2'h2 && !brk_req_o) [*2])
    else $error("final state left before the session ended");
  chk_armed_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[4:2] == 3'h2 && armed_o
    |-> avs_readdata_o[15:0] == 16'h0000)
    else $error("trace read while armed returned data");
endmodule // tbc_trace_monitor
bind tbc_trace_ctrl tbc_trace_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .trigger_i(trigger_i), .brk_req_o(brk_req_o), .armed_o(armed_o), .state_o(state_o));
`default_nettype wire

// file: verilog/tbc_trace_ctrl.v
// Trace buffer, trigger alignment and final-state sequencer control.
// Assumes an Avalon-MM master on clk_i and core trace strobes on the same clock.
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defines.vh"

// Behaviour
// - Arm write enters state 1; clearing returns quietly
// - Begin/mid: hold final until session completes
// - Tracing off or end: final returns immediately
// - 64x64 circular RAM; counter per entry
// - Store only while trace source enabled
// - End and mid alignment wrap around
// - No capture while background debug active
// - 16-bit reads advance the read pointer
// - Read while armed: invalid, pointer kept
// - Detail mode may restrict to C..D window
// - Event forces entries only normal/loop1; gating always
// - Align field selects session start and end
// - Begin: store from final, 64 lines
// - Begin: triggering flow instruction is recorded
// - Begin/mid breakpoint only on return to 0
// - Mid: exactly 32 lines after trigger
// - Pure PC mid: mark last entry before trigger
// - End: trigger flow instruction not recorded
// - Four modes; timestamp in normal, loop1, detail
// - Normal mode records listed flow addresses
// - Direct branches, calls, background entry ignored
// - Entry holds full address plus info byte
module tbc_trace_ctrl #(
  parameter ADDR_W = 24,
  parameter LINES  = 64,
  parameter PTR_W  = 6,
  parameter TS_W   = 16
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire [4:0]        avs_address_i,
  input  wire              avs_read_i,
  input  wire              avs_write_i,
  input  wire [31:0]       avs_writedata_i,
  input  wire [3:0]        avs_byteenable_i,
  output reg  [31:0]       avs_readdata_o,
  output reg               avs_waitrequest_o,
  input  wire              trigger_i,
  input  wire              cof_valid_i,
  input  wire [3:0]        cof_kind_i,
  input  wire [ADDR_W-1:0] cof_addr_i,
  input  wire              pc_valid_i,
  input  wire [ADDR_W-1:0] pc_i,
  input  wire              acc_valid_i,
  input  wire [ADDR_W-1:0] acc_addr_i,
  input  wire [15:0]       acc_data_i,
  input  wire              acc_write_i,
  input  wire              bdc_active_i,
  input  wire              eev_pin_i,
  output reg               brk_req_o,
  output reg               armed_o,
  output reg  [1:0]        state_o
);

  reg  [63:0]       ram [0:LINES-1];
  reg  [31:0]       ctrl_ff;
  reg  [ADDR_W-1:0] cmpc_ff;
  reg  [ADDR_W-1:0] cmpd_ff;
  reg  [1:0]        state_ff;
  reg  [PTR_W-1:0]  wline_ff;
  reg               half_ff;
  reg  [31:0]       lo_ff;
  reg               wrap_ff;
  reg  [6:0]        ent_cnt_ff;
  reg  [6:0]        post_cnt_ff;
  reg  [PTR_W+1:0]  rptr_ff;
  reg  [TS_W-1:0]   ts_ff;
  reg  [ADDR_W-1:0] last_addr_ff;
  reg               last_v_ff;
  reg  [PTR_W-1:0]  last_line_ff;
  reg  [63:0]       last_data_ff;
  reg               last_hi_ff;
  reg               eev_s1_ff;
  reg               eev_s2_ff;
  reg               eev_s3_ff;

  wire [1:0] align   = ctrl_ff[`TBC_CTL_ALIGN];
  wire [1:0] mode    = ctrl_ff[`TBC_CTL_MODE];
  wire [1:0] eev_cfg = ctrl_ff[`TBC_CTL_EEV];
  wire       tse     = ctrl_ff[`TBC_CTL_TSE];
  wire       brk_en  = ctrl_ff[`TBC_CTL_BRKEN];
  wire       timestamp_enable   = ctrl_ff[`TBC_CTL_TIMESTAMP_ENABLE];

  // Bus handshake: every access answers one cycle after it is seen
  wire req      = avs_read_i | avs_write_i;
  wire acc_done = req & ~avs_waitrequest_o;
  wire wr_done  = acc_done & avs_write_i;
  wire rd_done  = acc_done & avs_read_i;
  wire wr_ctrl  = wr_done & (avs_address_i[4:2] == `TBC_OFS_CTRL >> 2);
  wire wr_trace = wr_done & (avs_address_i[4:2] == `TBC_OFS_TRACE >> 2);
  wire rd_trace = rd_done & (avs_address_i[4:2] == `TBC_OFS_TRACE >> 2);

  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] ctrl_wv = (ctrl_ff & ~be_mask) | (avs_writedata_i & be_mask);

  // External event pin: level from second stage, edge from second and third
  wire eev_lvl  = eev_s2_ff;
  wire eev_rise = eev_s2_ff & ~eev_s3_ff;

  wire sw_trig  = wr_ctrl & ctrl_wv[`TBC_CTL_TRIG];
  wire trig_ev  = (state_ff == `TBC_ST_ARMED) & (trigger_i | sw_trig);

  // Flow classification
  reg        cof_rec;
  reg  [1:0] cet;
  always @* begin
    cof_rec = cof_valid_i;
    cet     = `TBC_CET_NONCOF;
    case (cof_kind_i)
      `TBC_K_CONDBR, `TBC_K_LOOP: cet = `TBC_CET_SRC;
      `TBC_K_IJMP, `TBC_K_IJSR, `TBC_K_RTI, `TBC_K_RTS: cet = `TBC_CET_DST;
      `TBC_K_VECTOR: cet = `TBC_CET_VEC;
      default: cof_rec = 1'b0;
    endcase
  end

  wire md_nl      = (mode == `TBC_MD_NORMAL) | (mode == `TBC_MD_LOOP1);
  wire eev_force  = (eev_cfg == `TBC_EEV_FORCE) & eev_rise & md_nl;
  wire gate_ok    = (eev_cfg != `TBC_EEV_GATE) | eev_lvl;
  wire in_window  = (acc_addr_i >= cmpc_ff) & (acc_addr_i <= cmpd_ff);
  wire range_ok   = (ctrl_ff[`TBC_CTL_RANGE] != `TBC_RG_INSIDE) | in_window;
  wire loop_dup   = (mode == `TBC_MD_LOOP1) & last_v_ff & (cof_addr_i == last_addr_ff);
  wire one_line   = (mode == `TBC_MD_DETAIL) | (timestamp_enable & md_nl);
  wire pure_mark  = (mode == `TBC_MD_PUREPC) & (align == `TBC_AL_MID) & trig_ev;

  // Entry candidate for the current mode
  reg              ent_v;
  reg  [ADDR_W-1:0] ent_addr;
  reg  [7:0]       ent_info;
  always @* begin
    ent_v    = 1'b0;
    ent_addr = pc_i;
    ent_info = 8'h00;
    case (mode)
      `TBC_MD_NORMAL, `TBC_MD_LOOP1: begin
        ent_v    = (cof_rec & ~(loop_dup & ~eev_force)) | eev_force;
        ent_addr = cof_rec ? cof_addr_i : pc_i;
        ent_info = {(cof_rec ? cet : `TBC_CET_NONCOF), 3'h0, eev_force, 2'h0};
      end
      `TBC_MD_DETAIL: begin
        ent_v    = acc_valid_i & range_ok;
        ent_addr = acc_addr_i;
        ent_info = {7'h00, acc_write_i};
      end
      `TBC_MD_PUREPC: begin
        ent_v    = pc_valid_i;
        ent_addr = pc_i;
        ent_info = 8'h00;
      end
      default: ent_v = 1'b0;
    endcase
  end

  wire [31:0] e32_raw = {ent_info, ent_addr};
  wire [31:0] e32     = e32_raw | ({31'h0, pure_mark} << `TBC_INF_MARK);
  wire [15:0] ts_fld  = timestamp_enable ? ts_ff : 16'h0000;

  // Storage window by alignment
  reg win;
  always @* begin
    case (align)
      `TBC_AL_BEGIN: win = (state_ff == `TBC_ST_FINAL) | trig_ev;
      `TBC_AL_MID:   win = (state_ff == `TBC_ST_ARMED) | (state_ff == `TBC_ST_FINAL);
      default:       win = (state_ff == `TBC_ST_ARMED) & ~trig_ev;
    endcase
  end

  wire store     = ent_v & win & tse & ~bdc_active_i & gate_ok;
  wire line_done = store & (one_line | half_ff);
  wire patch     = pure_mark & ~store & last_v_ff;

  reg [63:0] line_wd;
  always @* begin
    if (mode == `TBC_MD_DETAIL)
      line_wd = {ts_fld, acc_data_i, e32};
    else if (one_line)
      line_wd = {ts_fld, 16'h0000, e32};
    else if (half_ff)
      line_wd = {e32, lo_ff};
    else
      line_wd = {32'h0000_0000, e32};
  end

  wire [63:0] patch_wd = last_data_ff |
                         (last_hi_ff ? ({63'h0, 1'b1} << (32 + `TBC_INF_MARK))
                                     : ({63'h0, 1'b1} << `TBC_INF_MARK));

  always @(posedge clk_i) begin
    if (store)
      ram[wline_ff] <= line_wd;
    else if (patch)
      ram[last_line_ff] <= patch_wd;
  end

  // Session completion for begin and mid alignment
  wire [6:0] sess_len = (align == `TBC_AL_BEGIN) ? `TBC_BEGIN_LINES : `TBC_MID_LINES;
  wire       held     = tse & ((align == `TBC_AL_BEGIN) | (align == `TBC_AL_MID));
  wire       sess_end = line_done & (state_ff == `TBC_ST_FINAL) &
                        (post_cnt_ff == sess_len - 7'h01);

  reg [1:0] nxt_state;
  reg       nxt_brk;
  always @* begin
    nxt_state = state_ff;
    nxt_brk   = 1'b0;
    case (state_ff)
      `TBC_ST_IDLE:
        if (wr_ctrl & ctrl_wv[`TBC_CTL_ARM])
          nxt_state = `TBC_ST_ARMED;
      `TBC_ST_ARMED:
        if (wr_ctrl & ~ctrl_wv[`TBC_CTL_ARM])
          nxt_state = `TBC_ST_IDLE;
        else if (trig_ev)
          nxt_state = `TBC_ST_FINAL;
      `TBC_ST_FINAL:
        if (~held | sess_end) begin
          nxt_state = `TBC_ST_IDLE;
          nxt_brk   = brk_en;
        end else if (wr_ctrl & ~ctrl_wv[`TBC_CTL_ARM])
          nxt_state = `TBC_ST_IDLE;
      default: nxt_state = `TBC_ST_IDLE;
    endcase
  end

  wire hw_disarm = (state_ff == `TBC_ST_FINAL) & (~held | sess_end);
  wire arming    = (state_ff == `TBC_ST_IDLE) & (nxt_state == `TBC_ST_ARMED);
  wire to_idle   = (state_ff != `TBC_ST_IDLE) & (nxt_state == `TBC_ST_IDLE);

  // Sequencer, control and status
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= `TBC_ST_IDLE;
      ctrl_ff   <= `TBC_CTL_RESET;
      brk_req_o <= 1'b0;
      armed_o   <= 1'b0;
      state_o   <= `TBC_ST_IDLE;
      cmpc_ff   <= {ADDR_W{1'b0}};
      cmpd_ff   <= {ADDR_W{1'b0}};
    end else begin
      state_ff  <= nxt_state;
      brk_req_o <= nxt_brk;
      armed_o   <= (nxt_state != `TBC_ST_IDLE);
      state_o   <= nxt_state;
      if (wr_ctrl)
        ctrl_ff <= ctrl_wv & `TBC_CTL_MASK & ~(32'h1 << `TBC_CTL_TRIG);
      // Hardware disarm beats a simultaneous arm write
      if (hw_disarm)
        ctrl_ff[`TBC_CTL_ARM] <= 1'b0;
      if (wr_done & (avs_address_i[4:2] == `TBC_OFS_CMPC >> 2))
        cmpc_ff <= avs_writedata_i[ADDR_W-1:0];
      if (wr_done & (avs_address_i[4:2] == `TBC_OFS_CMPD >> 2))
        cmpd_ff <= avs_writedata_i[ADDR_W-1:0];
    end
  end

  // Write side pointers and counters
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wline_ff     <= {PTR_W{1'b0}};
      half_ff      <= 1'b0;
      lo_ff        <= 32'h0000_0000;
      wrap_ff      <= 1'b0;
      ent_cnt_ff   <= 7'h00;
      post_cnt_ff  <= 7'h00;
      last_addr_ff <= {ADDR_W{1'b0}};
      last_v_ff    <= 1'b0;
      last_line_ff <= {PTR_W{1'b0}};
      last_data_ff <= 64'h0;
      last_hi_ff   <= 1'b0;
    end else if (arming) begin
      wline_ff    <= {PTR_W{1'b0}};
      half_ff     <= 1'b0;
      wrap_ff     <= 1'b0;
      ent_cnt_ff  <= 7'h00;
      post_cnt_ff <= 7'h00;
      last_v_ff   <= 1'b0;
    end else if (store) begin
      ent_cnt_ff   <= ent_cnt_ff + 7'h01;
      last_addr_ff <= ent_addr;
      last_v_ff    <= 1'b1;
      last_line_ff <= wline_ff;
      last_data_ff <= line_wd;
      last_hi_ff   <= half_ff & ~one_line;
      if (line_done) begin
        half_ff  <= 1'b0;
        wline_ff <= wline_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        if (wline_ff == LINES - 1)
          wrap_ff <= 1'b1;
        if (state_ff == `TBC_ST_FINAL)
          post_cnt_ff <= post_cnt_ff + 7'h01;
      end else begin
        half_ff <= 1'b1;
        lo_ff   <= e32;
      end
    end else if (patch) begin
      last_data_ff <= patch_wd;
      if (~last_hi_ff)
        lo_ff <= lo_ff | (32'h1 << `TBC_INF_MARK);
    end
  end

  // Read pointer: starts at the oldest line once the session closes
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      rptr_ff <= {(PTR_W+2){1'b0}};
    else if (to_idle)
      rptr_ff <= wrap_ff ? {wline_ff, 2'b00} : {(PTR_W+2){1'b0}};
    else if (wr_trace)
      rptr_ff <= {(PTR_W+2){1'b0}};
    else if (rd_trace & (state_ff == `TBC_ST_IDLE))
      rptr_ff <= rptr_ff + {{(PTR_W+1){1'b0}}, 1'b1};
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      ts_ff <= {TS_W{1'b0}};
    else
      ts_ff <= ts_ff + {{(TS_W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eev_s1_ff <= 1'b0;
      eev_s2_ff <= 1'b0;
      eev_s3_ff <= 1'b0;
    end else begin
      eev_s1_ff <= eev_pin_i;
      eev_s2_ff <= eev_s1_ff;
      eev_s3_ff <= eev_s2_ff;
    end
  end

  // Read data mux
  wire [63:0] rline = ram[rptr_ff[PTR_W+1:2]];
  reg  [15:0] rword;
  reg  [31:0] rd_mux;
  always @* begin
    case (rptr_ff[1:0])
      2'h0:    rword = rline[15:0];
      2'h1:    rword = rline[31:16];
      2'h2:    rword = rline[47:32];
      default: rword = rline[63:48];
    endcase
    case (avs_address_i[4:2])
      `TBC_OFS_CTRL >> 2:   rd_mux = ctrl_ff;
      `TBC_OFS_STATUS >> 2: rd_mux = {10'h000, rptr_ff[PTR_W+1:2], 1'b0, ent_cnt_ff,
                                      4'h0, wrap_ff, (state_ff != `TBC_ST_IDLE), state_ff};
      `TBC_OFS_TRACE >> 2:  rd_mux = {16'h0000, (state_ff == `TBC_ST_IDLE) ? rword
                                                                         : `TBC_INVALID_WORD};
      `TBC_OFS_CMPC >> 2:   rd_mux = {8'h00, cmpc_ff};
      `TBC_OFS_CMPD >> 2:   rd_mux = {8'h00, cmpd_ff};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= rd_mux;
    end
  end

endmodule // tbc_trace_ctrl
`default_nettype wire
